// File: shared/alt_pipe_pkg.sv
package alt_pipe_pkg;

   // ----------------------------------------------------------------
   // data path shape
   // ----------------------------------------------------------------
   localparam int SAMPLE_W   = 24;
   localparam int FIFO_DEPTH = 4;
   localparam int ACC_W      = 40;

   // ----------------------------------------------------------------
   // reference energy decision
   // ----------------------------------------------------------------
   // per-frame sum of |ref| at or above this counts as far-end audio
   localparam logic [ACC_W-1:0] ENERGY_THRESH = 40'h00_0010_0000;

   // ----------------------------------------------------------------
   // enable setting encoding
   // ----------------------------------------------------------------
   localparam logic ALT_OFF = 1'b0;
   localparam logic ALT_ON  = 1'b1;

   // ----------------------------------------------------------------
   // echo canceller characteristics
   // ----------------------------------------------------------------
   localparam int               DELAY_W            = 8;
   localparam logic [DELAY_W-1:0] STD_ECHO_DELAY_MS = 8'd150;
   localparam logic [DELAY_W-1:0] ALT_ECHO_DELAY_MS = 8'd225;
   localparam logic [DELAY_W-1:0] NO_ECHO_DELAY_MS  = 8'd0;
   localparam int               PHASE_W            = 5;
   localparam logic [PHASE_W-1:0] ALT_PHASES        = 5'd15;
   localparam logic [PHASE_W-1:0] STD_PHASES_DFLT   = 5'd10;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_REF_PRESENT = 1'b0;
   localparam logic RST_BYPASS      = 1'b0;

   // ----------------------------------------------------------------
   // pipeline configurations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIPE_STD,
      PIPE_EC_ONLY,
      PIPE_IC_ONLY
   } pipe_mode_t;

endpackage

// File: logic/sample_fifo.sv
`timescale 1ns/100ps
module sample_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   // filling side
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   // draining side
   output logic [WIDTH-1:0]      out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sample_fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [CW-1:0]               count;
      logic                        in_ready;
      logic                        out_valid;
   } fifo_state_t;

   fifo_state_t q;
   fifo_state_t d;
   logic        push;
   logic        pop;

   // next state; flags are registered so in_ready and out_valid come from flops
   always_comb begin
      d    = q;
      push = in_valid_in & q.in_ready;
      pop  = q.out_valid & out_ready_in;
      if (push) begin
         d.mem[q.wr_ptr] = in_data_in;
         d.wr_ptr        = q.wr_ptr + 1'b1;
      end
      if (pop) begin
         d.rd_ptr = q.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         d.count = q.count + 1'b1;
      end else if (pop && !push) begin
         d.count = q.count - 1'b1;
      end
      d.in_ready  = (d.count != FULL_COUNT);
      d.out_valid = (d.count != '0);
   end

   // state register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q          <= '0;
         q.in_ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_ready_out  = q.in_ready;
   assign out_valid_out = q.out_valid;
   assign out_data_out  = q.mem[q.rd_ptr];

endmodule

// File: logic/ref_energy_stats.sv
`timescale 1ns/100ps
module ref_energy_stats #(
   parameter int                   SAMPLE_W = 24,
   parameter int                   ACC_W    = 40,
   parameter logic [ACC_W-1:0]     THRESH   = alt_pipe_pkg::ENERGY_THRESH
) (
   // clock and reset
   input  wire logic                clk_in,
   input  wire logic                reset_n_in,
   // far-end reference samples
   input  wire logic [SAMPLE_W-1:0] ref_data_in,
   input  wire logic                ref_valid_in,
   // frame boundary pulse
   input  wire logic                frame_start_in,
   // decision for the frame just closed
   output logic                     ref_present_out
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (SAMPLE_W < 2 || ACC_W <= SAMPLE_W) begin : g_bad_width
      $error("ref_energy_stats needs ACC_W wider than SAMPLE_W");
   end

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic             present;
   } stats_state_t;

   stats_state_t        q;
   stats_state_t        d;
   logic [SAMPLE_W-1:0] mag;
   logic [ACC_W:0]      sum;
   logic [ACC_W-1:0]    base;

   // magnitude sum saturates so a loud frame never wraps to quiet
   always_comb begin
      d    = q;
      mag  = ref_data_in[SAMPLE_W-1] ? (~ref_data_in + 1'b1) : ref_data_in;
      base = q.acc;
      if (frame_start_in) begin
         d.present = (q.acc >= THRESH);
         base      = '0;
      end
      sum   = {1'b0, base} + {{(ACC_W - SAMPLE_W + 1){1'b0}}, mag};
      d.acc = base;
      if (ref_valid_in) begin
         d.acc = sum[ACC_W] ? '1 : sum[ACC_W-1:0];
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q         <= '0;
         q.present <= alt_pipe_pkg::RST_REF_PRESENT;
      end else begin
         q <= d;
      end
   end

   assign ref_present_out = q.present;

endmodule

// File: logic/alt_pipeline_mode_switch.sv
`timescale 1ns/100ps
module alt_pipeline_mode_switch #(
   parameter int                          SAMPLE_W   =
      alt_pipe_pkg::SAMPLE_W,
   parameter int                          FIFO_DEPTH =
      alt_pipe_pkg::FIFO_DEPTH,
   parameter logic [alt_pipe_pkg::PHASE_W-1:0] STD_PHASES =
      alt_pipe_pkg::STD_PHASES_DFLT
) (
   // clock and reset
   input  wire logic                              SYS_CLK_IN,
   input  wire logic                              RESET_N_IN,
   // control interface settings
   input  wire logic                              ALT_ENABLE_IN,
   input  wire logic                              MANUAL_EC_BYPASS_IN,
   input  wire logic                              MANUAL_IC_BYPASS_IN,
   // microphone audio in
   input  wire logic [SAMPLE_W-1:0]               AUDIO_DATA_IN,
   input  wire logic                              AUDIO_FIRST_IN,
   input  wire logic                              AUDIO_VALID_IN,
   output logic                                   AUDIO_READY_OUT,
   // far-end reference in
   input  wire logic [SAMPLE_W-1:0]               REF_DATA_IN,
   input  wire logic                              REF_VALID_IN,
   // audio out toward the cancellers
   output logic [SAMPLE_W-1:0]                    AUDIO_DATA_OUT,
   output logic                                   AUDIO_FIRST_OUT,
   output logic                                   AUDIO_VALID_OUT,
   input  wire logic                              AUDIO_READY_IN,
   // pipeline configuration for the frame on the output
   output logic [1:0]                             PIPE_MODE_OUT,
   output logic                                   EC_BYPASS_OUT,
   output logic                                   IC_BYPASS_OUT,
   output logic                                   EC_SINGLE_MIC_OUT,
   output logic [alt_pipe_pkg::PHASE_W-1:0]       EC_PHASES_OUT,
   output logic                                   MEM_REALLOC_OUT,
   output logic [alt_pipe_pkg::DELAY_W-1:0]       ECHO_DELAY_MS_OUT,
   output logic                                   REF_PRESENT_OUT
);

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (SAMPLE_W < 2 || SAMPLE_W >= alt_pipe_pkg::ACC_W) begin : g_bad_w
      $error("sample width must lie between 2 and the accumulator");
   end
   if (STD_PHASES == '0) begin : g_bad_phases
      $error("standard phase count must be non-zero");
   end

   localparam int FW = SAMPLE_W + 1;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SAMPLE_W-1:0]                    out_data;
      logic                                   out_first;
      logic                                   out_valid;
      alt_pipe_pkg::pipe_mode_t               mode;
      logic                                   ec_bypass;
      logic                                   ic_bypass;
      logic                                   single_mic;
      logic [alt_pipe_pkg::PHASE_W-1:0]       phases;
      logic                                   realloc;
      logic [alt_pipe_pkg::DELAY_W-1:0]       delay_ms;
   } sw_state_t;

   sw_state_t     q;
   sw_state_t     d;

   logic          fifo_in_ready;
   logic [FW-1:0] fifo_out_data;
   logic          fifo_out_valid;
   logic          fifo_out_ready;
   logic          in_frame_start;
   logic          ref_present;

   // ----------------------------------------------------------------
   // data path buffer
   // ----------------------------------------------------------------
   // the first-of-frame mark travels with each word so the switch
   // happens exactly where that frame leaves the buffer
   sample_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) sample_fifo_inst (
      .clk_in        (SYS_CLK_IN),
      .reset_n_in    (RESET_N_IN),
      .in_data_in    ({AUDIO_FIRST_IN, AUDIO_DATA_IN}),
      .in_valid_in   (AUDIO_VALID_IN),
      .in_ready_out  (fifo_in_ready),
      .out_data_out  (fifo_out_data),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready)
   );

   // ----------------------------------------------------------------
   // reference statistics
   // ----------------------------------------------------------------
   // frame boundary is seen when a first sample is accepted at input
   assign in_frame_start = AUDIO_VALID_IN & fifo_in_ready & AUDIO_FIRST_IN;

   ref_energy_stats #(
      .SAMPLE_W (SAMPLE_W),
      .ACC_W    (alt_pipe_pkg::ACC_W),
      .THRESH   (alt_pipe_pkg::ENERGY_THRESH)
   ) ref_energy_stats_inst (
      .clk_in          (SYS_CLK_IN),
      .reset_n_in      (RESET_N_IN),
      .ref_data_in     (REF_DATA_IN),
      .ref_valid_in    (REF_VALID_IN),
      .frame_start_in  (in_frame_start),
      .ref_present_out (ref_present)
   );

   // ----------------------------------------------------------------
   // output stage and configuration select
   // ----------------------------------------------------------------
   // output register reloads when empty or when taken downstream
   assign fifo_out_ready = !q.out_valid || AUDIO_READY_IN;

   always_comb begin
      d = q;
      if (fifo_out_ready) begin
         d.out_valid = fifo_out_valid;
         if (fifo_out_valid) begin
            d.out_data  = fifo_out_data[SAMPLE_W-1:0];
            d.out_first = fifo_out_data[SAMPLE_W];
         end
      end
      // settings are sampled only with a frame's first word
      if (fifo_out_ready && fifo_out_valid &&
          fifo_out_data[SAMPLE_W]) begin
         if (ALT_ENABLE_IN == alt_pipe_pkg::ALT_OFF) begin
            // standard: both run unless bypassed by hand
            d.mode       = alt_pipe_pkg::PIPE_STD;
            d.ec_bypass  = MANUAL_EC_BYPASS_IN;
            d.ic_bypass  = MANUAL_IC_BYPASS_IN;
            d.single_mic = 1'b0;
            d.phases     = STD_PHASES;
            d.realloc    = 1'b0;
            d.delay_ms   = alt_pipe_pkg::STD_ECHO_DELAY_MS;
         end else if (ref_present) begin
            // far end active: echo canceller alone, long tail
            d.mode       = alt_pipe_pkg::PIPE_EC_ONLY;
            d.ec_bypass  = MANUAL_EC_BYPASS_IN;
            d.ic_bypass  = 1'b1;
            d.single_mic = 1'b1;
            d.phases     = alt_pipe_pkg::ALT_PHASES;
            d.realloc    = 1'b1;
            d.delay_ms   = alt_pipe_pkg::ALT_ECHO_DELAY_MS;
         end else begin
            // far end silent: interference canceller alone
            d.mode       = alt_pipe_pkg::PIPE_IC_ONLY;
            d.ec_bypass  = 1'b1;
            d.ic_bypass  = MANUAL_IC_BYPASS_IN;
            d.single_mic = 1'b0;
            d.phases     = STD_PHASES;
            d.realloc    = 1'b0;
            d.delay_ms   = alt_pipe_pkg::NO_ECHO_DELAY_MS;
         end
      end
   end

   // state register; reset lands in standard configuration
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         q            <= '0;
         q.mode       <= alt_pipe_pkg::PIPE_STD;
         q.ec_bypass  <= alt_pipe_pkg::RST_BYPASS;
         q.ic_bypass  <= alt_pipe_pkg::RST_BYPASS;
         q.phases     <= STD_PHASES;
         q.delay_ms   <= alt_pipe_pkg::STD_ECHO_DELAY_MS;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------
   assign AUDIO_READY_OUT   = fifo_in_ready;
   assign AUDIO_DATA_OUT    = q.out_data;
   assign AUDIO_FIRST_OUT   = q.out_first;
   assign AUDIO_VALID_OUT   = q.out_valid;
   assign PIPE_MODE_OUT     = q.mode;
   assign EC_BYPASS_OUT     = q.ec_bypass;
   assign IC_BYPASS_OUT     = q.ic_bypass;
   assign EC_SINGLE_MIC_OUT = q.single_mic;
   assign EC_PHASES_OUT     = q.phases;
   assign MEM_REALLOC_OUT   = q.realloc;
   assign ECHO_DELAY_MS_OUT = q.delay_ms;
   assign REF_PRESENT_OUT   = ref_present;

endmodule

// File: test/far_side_model.sv
`timescale 1ns/100ps
module far_side_model (
   // clock
   input  wire logic   clk_in,
   // scenario controls
   input  wire logic   loud_in,
   input  wire logic   stall_in,
   // far-end reference and sink ready
   output logic [23:0] ref_data_out,
   output logic        ref_valid_out,
   output logic        ready_out
);
   logic [1:0]  cnt;
   logic [23:0] amp;

   // sign flips every other sample so only the magnitude adds up
   initial begin
      cnt = 2'h0;
      ref_valid_out = 1'b0;
      ref_data_out = 24'h000000;
      ready_out = 1'b1;
   end
   always @(posedge clk_in) begin
      #1;
      cnt = cnt + 2'h1;
      amp = loud_in ? 24'h040000 : 24'h000010;
      ref_valid_out = cnt[0];
      // off-sample cycles carry a moving pattern, not stale data
      ref_data_out = !cnt[0] ? {cnt, 22'h2aaaaa} : cnt[1] ? -amp : amp;
      ready_out = !stall_in;
   end
endmodule

// File: test/alt_pipeline_mode_switch_checker.sv
`timescale 1ns/100ps
module alt_pipeline_mode_switch_checker #(
   parameter logic [alt_pipe_pkg::PHASE_W-1:0] STD_PHASES =
      alt_pipe_pkg::STD_PHASES_DFLT
) (
   // clock and reset
   input wire logic        SYS_CLK_IN,
   input wire logic        RESET_N_IN,
   // watched ports
   input wire logic        ALT_ENABLE_IN,
   input wire logic        MANUAL_EC_BYPASS_IN,
   input wire logic        MANUAL_IC_BYPASS_IN,
   input wire logic        AUDIO_READY_OUT,
   input wire logic [23:0] AUDIO_DATA_OUT,
   input wire logic        AUDIO_FIRST_OUT,
   input wire logic        AUDIO_VALID_OUT,
   input wire logic        AUDIO_READY_IN,
   input wire logic [1:0]  PIPE_MODE_OUT,
   input wire logic        EC_BYPASS_OUT,
   input wire logic        IC_BYPASS_OUT,
   input wire logic        EC_SINGLE_MIC_OUT,
   input wire logic [4:0]  EC_PHASES_OUT,
   input wire logic        MEM_REALLOC_OUT,
   input wire logic [7:0]  ECHO_DELAY_MS_OUT
);
   logic [18:0] cfg;
   logic        fst;

   // one vector so any config change is caught at once
   assign cfg = {PIPE_MODE_OUT, EC_BYPASS_OUT, IC_BYPASS_OUT,
      EC_SINGLE_MIC_OUT, EC_PHASES_OUT, MEM_REALLOC_OUT, ECHO_DELAY_MS_OUT};
   assign fst = AUDIO_VALID_OUT && AUDIO_FIRST_OUT;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   sequence s_start;
      fst && !$past(fst);
   endsequence

   a_cfg_at_frame: assert property ($changed(cfg) |-> fst)
      else $error("config moved inside a frame");
   a_std_both: assert property (PIPE_MODE_OUT == 2'h0 |->
      ECHO_DELAY_MS_OUT == 8'h96 && !MEM_REALLOC_OUT && !EC_SINGLE_MIC_OUT
      && EC_PHASES_OUT == STD_PHASES) else $error("standard config wrong");
   a_ec_only: assert property (PIPE_MODE_OUT == 2'h1 |-> IC_BYPASS_OUT
      && EC_SINGLE_MIC_OUT && EC_PHASES_OUT == 5'h0f && MEM_REALLOC_OUT
      && ECHO_DELAY_MS_OUT == 8'he1) else $error("echo-only config wrong");
   a_ic_only: assert property (PIPE_MODE_OUT == 2'h2 |-> EC_BYPASS_OUT
      && !MEM_REALLOC_OUT && ECHO_DELAY_MS_OUT == 8'h00)
      else $error("interference-only config wrong");
   a_realloc_auto: assert property (MEM_REALLOC_OUT |-> PIPE_MODE_OUT == 2'h1)
      else $error("memory moved outside echo-only");
   a_std_manual: assert property (s_start ##0 !$past(ALT_ENABLE_IN) |->
      PIPE_MODE_OUT == 2'h0 && EC_BYPASS_OUT == $past(MANUAL_EC_BYPASS_IN)
      && IC_BYPASS_OUT == $past(MANUAL_IC_BYPASS_IN))
      else $error("standard frame ignores settings");
   a_alt_split: assert property (s_start ##0 $past(ALT_ENABLE_IN) |->
      PIPE_MODE_OUT != 2'h0 && EC_BYPASS_OUT ==
      (PIPE_MODE_OUT == 2'h2 || $past(MANUAL_EC_BYPASS_IN)))
      else $error("alternate frame config wrong");
   a_out_stands: assert property (AUDIO_VALID_OUT && !AUDIO_READY_IN |=>
      AUDIO_VALID_OUT && $stable({AUDIO_FIRST_OUT, AUDIO_DATA_OUT}))
      else $error("output word dropped while stalled");
   a_refuse_full: assert property (!AUDIO_READY_OUT |-> AUDIO_VALID_OUT)
      else $error("refusing with nothing held");
endmodule

bind alt_pipeline_mode_switch alt_pipeline_mode_switch_checker #(
   .STD_PHASES(STD_PHASES)
) alt_pipeline_mode_switch_checker_inst (
   .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
   .ALT_ENABLE_IN(ALT_ENABLE_IN), .MANUAL_EC_BYPASS_IN(MANUAL_EC_BYPASS_IN),
   .MANUAL_IC_BYPASS_IN(MANUAL_IC_BYPASS_IN),
   .AUDIO_READY_OUT(AUDIO_READY_OUT), .AUDIO_DATA_OUT(AUDIO_DATA_OUT),
   .AUDIO_FIRST_OUT(AUDIO_FIRST_OUT), .AUDIO_VALID_OUT(AUDIO_VALID_OUT),
   .AUDIO_READY_IN(AUDIO_READY_IN), .PIPE_MODE_OUT(PIPE_MODE_OUT),
   .EC_BYPASS_OUT(EC_BYPASS_OUT), .IC_BYPASS_OUT(IC_BYPASS_OUT),
   .EC_SINGLE_MIC_OUT(EC_SINGLE_MIC_OUT), .EC_PHASES_OUT(EC_PHASES_OUT),
   .MEM_REALLOC_OUT(MEM_REALLOC_OUT), .ECHO_DELAY_MS_OUT(ECHO_DELAY_MS_OUT)
);

// File: test/alt_pipeline_mode_switch_tb_top.sv
`timescale 1ns/100ps
module alt_pipeline_mode_switch_tb_top;
   logic        clk, rst_n, alt, mec, mic, loud, stall;
   logic [23:0] din, dout, rdata, seq_n;
   logic        fin, vin, rin, fout, vout, rdy, rvalid, rp;
   logic [1:0]  mode;
   logic        ecb, icb, single, realloc;
   logic [4:0]  ph;
   logic [7:0]  dly;
   logic [24:0] exp_q[$];
   int          mismatches, checked;
   wire  [18:0] cfg = {mode, ecb, icb, single, ph, realloc, dly};

   always #2 clk = ~clk;
   alt_pipeline_mode_switch alt_pipeline_mode_switch_inst (
      .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .ALT_ENABLE_IN(alt),
      .MANUAL_EC_BYPASS_IN(mec), .MANUAL_IC_BYPASS_IN(mic),
      .AUDIO_DATA_IN(din), .AUDIO_FIRST_IN(fin), .AUDIO_VALID_IN(vin),
      .AUDIO_READY_OUT(rdy), .REF_DATA_IN(rdata), .REF_VALID_IN(rvalid),
      .AUDIO_DATA_OUT(dout), .AUDIO_FIRST_OUT(fout), .AUDIO_VALID_OUT(vout),
      .AUDIO_READY_IN(rin), .PIPE_MODE_OUT(mode), .EC_BYPASS_OUT(ecb),
      .IC_BYPASS_OUT(icb), .EC_SINGLE_MIC_OUT(single), .EC_PHASES_OUT(ph),
      .MEM_REALLOC_OUT(realloc), .ECHO_DELAY_MS_OUT(dly),
      .REF_PRESENT_OUT(rp));
   far_side_model far_side_model_inst (.clk_in(clk), .loud_in(loud),
      .stall_in(stall), .ref_data_out(rdata), .ref_valid_out(rvalid),
      .ready_out(rin));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", what, want, seen);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic [18:0] want_cfg(logic a, e, i, l);
      if (!a) return {2'h0, e, i, 1'b0, 5'h0a, 1'b0, 8'h96};
      if (l) return {2'h1, e, 1'b1, 1'b1, 5'h0f, 1'b1, 8'he1};
      return {2'h2, 1'b1, i, 1'b0, 5'h0a, 1'b0, 8'h00};
   endfunction
   // every delivered word must match the oldest one sent, flag included
   always @(negedge clk) begin
      if (rst_n && vout && rin) begin
         check("word", {fout, dout}, exp_q.pop_front());
      end
   end
   task automatic idle(input int n);
      vin = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   // drops valid after the taking edge so no word is pushed twice
   task automatic send(input logic first);
      int n;
      n = 0;
      vin = 1'b1;
      fin = first;
      din = seq_n;
      while (!rdy && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      exp_q.push_back({first, seq_n});
      @(posedge clk);
      #1;
      vin = 1'b0;
      seq_n = seq_n + 24'h000001;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_modes();
      int n;
      logic [18:0] w;
      for (int c = 0; c < 16; c++) begin
         {alt, mec, mic, loud} = 4'(c);
         w = want_cfg(alt, mec, mic, loud);
         send(1'b1);
         idle(30);
         send(1'b1);
         n = 0;
         while (!(vout && fout) && n < 20) begin
            @(negedge clk);
            n++;
         end
         check("cfg", cfg, w);
         @(posedge clk);
         #1;
         alt = ~alt;
         repeat (5) @(negedge clk);
         check("hold", cfg, w);
         idle(30);
         send(1'b0);
         idle(4);
      end
   endtask
   task automatic t_fill();
      int n;
      n = 0;
      stall = 1'b1;
      fin = 1'b0;
      vin = 1'b1;
      din = seq_n;
      while (rdy && n < 10) begin
         exp_q.push_back({1'b0, seq_n});
         @(posedge clk);
         #1;
         n++;
         seq_n = seq_n + 24'h000001;
         din = seq_n;
      end
      idle(3);
      check("refused", {rdy, vout}, 2'b01);
      stall = 1'b0;
      idle(12);
      check("drained", {exp_q.size() == 0, vout}, 2'b10);
   endtask

   initial begin
      {clk, rst_n, alt, mec, mic, loud, stall, fin, vin} = 9'h000;
      din = 24'h000000;
      seq_n = 24'h000100;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      check("reset", {rdy, vout, rp, cfg},
            {3'b100, want_cfg(0, 0, 0, 0)});
      t_modes();
      t_fill();
      print_verdict();
   end
   // whole run is about 1200 cycles
   initial begin
      #80000;
      mismatches++;
      print_verdict();
   end
endmodule
